// ===== core/hsur_pkg.sv
/*
  constants, field layout and carrier types of the high-speed uart
  receive path with its apb register file.
  assumes one 200 MHz clock that also serves as the bit sample clock.
*/
`default_nettype none
package hsur_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_CORR = 8'h08;
  localparam logic [7:0] OFF_EOF = 8'h0c;
  localparam logic [7:0] OFF_EST_DIV = 8'h10;
  localparam logic [7:0] OFF_EST_CORR = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_BUFSZ = 8'h1c;
  localparam logic [7:0] OFF_BUFREL = 8'h20;
  // control fields
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_KEEP = 2;
  localparam int CTRL_RX_STOP2 = 3;
  localparam int CTRL_TX_STOP2 = 4;
  localparam int CTRL_TX_DIV1 = 5;
  localparam int CORR_TX_LO = 16;
  // status fields
  localparam int STAT_FER = 0;
  localparam int STAT_OVF = 1;
  localparam int STAT_EST = 2;
  localparam int STAT_BUF_LO = 3;
  // widths
  localparam int DIV_W = 12;
  localparam int CORR_W = 11;
  localparam int EOF_W = 7;
  localparam int BSZ_W = 10;
  // reset values
  localparam logic [DIV_W-1:0] DIV_RST = 12'h0eb;
  localparam logic [EOF_W-1:0] EOF_RST = 7'h0a;
  localparam logic [BSZ_W-1:0] BUFSZ_RST = 10'h3ff;
  localparam logic [2:0] NUM_BUFS = 3'h4;
  // fixed figures of the line protocol
  localparam logic [EOF_W-1:0] EOF_MAX = 7'h7a;
  localparam logic [3:0] CAL_BITS = 4'h9;
  localparam logic [3:0] START_PRELOAD = 4'h3;
  localparam logic [DIV_W-1:0] EST_OVF_DIV = 12'h3ff;
  localparam logic [3:0] LAST_STOP1 = 4'h9;
  localparam logic [3:0] LAST_STOP2 = 4'ha;
  // estimator modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hsur_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hsur_apb_rsp_t;

  typedef enum logic [1:0] {RX_IDLE, RX_CAL, RX_BITS, RX_GAP} hsur_rx_st_t;
  typedef enum logic {TX_IDLE, TX_BITS} hsur_tx_st_t;
endpackage
`default_nettype wire

// ===== core/hsur_receiver.sv
/*
  high-speed uart host receive path: bit sampler, end-of-frame detection,
  rate estimator, rts/cts flow control, byte transmitter, apb registers.
  assumes clk is the sample clock; the buffer manager takes one received
  byte per rx_valid pulse and holds tx_valid/tx_data until tx_ack.
*/
// Functional notes
// - frame ends after the programmed number of consecutive idle one bits.
// - estimator counts cycles over nine zero bits, divides by nine, reports.
// - estimator mode 1 applies estimated divider and correction to rx and tx.
// - estimator mode 2 only reports; programmed values stay in use.
// - auto mode transmit uses programmed values until a reception occurred.
// - calibration byte goes to the buffer only when the keep flag is set.
// - estimator overflow raises framing error and forces divider to 1023.
// - cts is sampled before each byte; byte waits while cts is high.
// - rts falls when a buffer frees, rises at frame end if none left.
// - all buffers available after reset so rts starts low.
// - overflowing frame raises overflow, keeps rts low, drops extra bytes.
// - falling edge on rx is resynchronised, then cycles time each bit.
// - each bit is sampled when the counter reaches half the divider.
// - the cycle counter is preloaded with three at start detection; the bit index starts at zero.
// - bit length is divider plus its correction bit, indexed start to stop.
// - firmware sets timing, frees a buffer, rts falls, waits frame end.
// - a stop bit sampled low raises framing error; reception continues.
// - eight data bits, lsb first, between a zero start bit and stop bits.
// - stop bit count is one or two, separately for rx and tx.
// - end-of-frame length ranges from one to 122 bit periods.
`default_nettype none
module hsur_receiver #(
  parameter int EST_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire hsur_pkg::hsur_apb_req_t apb_req,
  output hsur_pkg::hsur_apb_rsp_t apb_rsp,
  // uart pins
  input wire logic rx_line,
  input wire logic cts_b,
  output logic tx_line,
  output logic rts_b,
  // buffer manager side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic eor,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ack,
  // sticky event flags
  output logic fer_flag,
  output logic ovf_flag
);
  import hsur_pkg::*;

  function automatic logic [CORR_W-1:0] spread(input logic [3:0] rem);
    logic [CORR_W-1:0] p;
    p = '0;
    for (int i = 0; i < CORR_W; i++) begin
      p[i] = (((i + 1) * rem) / 9) > ((i * rem) / 9);
    end
    return p;
  endfunction

  function automatic logic [DIV_W:0] bitlen(input logic [DIV_W-1:0] d,
      input logic [CORR_W-1:0] c, input logic [3:0] idx);
    return {1'b0, d} + {{DIV_W{1'b0}}, c[idx]};
  endfunction

  // registers
  logic [5:0] ctrl_r;
  logic [DIV_W-1:0] div_r, est_div_r;
  logic [CORR_W-1:0] rx_corr_r, tx_corr_r, est_corr_r;
  logic [EOF_W-1:0] eof_r;
  logic [BSZ_W-1:0] bufsz_r;
  logic est_valid_r, fer_r, ovf_r;
  logic [2:0] bufcnt_r;
  hsur_apb_rsp_t rsp_r;

  // rx path state
  hsur_rx_st_t rx_st_r;
  logic rx_s1_r, rx_s2_r, rx_s3_r;
  logic [DIV_W:0] cnt_r;
  logic [3:0] bi_r;
  logic [7:0] sh_r;
  logic [EST_W-1:0] ecnt_r;
  logic [EOF_W-1:0] eofcnt_r;
  logic [BSZ_W:0] bytes_r;
  logic ovf_frame_r, rx_valid_r, eor_r, rts_b_r;
  logic [7:0] rx_data_r;
  logic fer_set, ovf_set, deliver;

  // tx path state
  hsur_tx_st_t tx_st_r;
  logic [DIV_W:0] tcnt_r;
  logic [3:0] tbi_r;
  logic [9:0] tsh_r;
  logic tx_line_r, tx_ack_r;

  // derived
  logic [1:0] mode;
  logic use_est;
  logic [DIV_W-1:0] rdiv, tdiv;
  logic [CORR_W-1:0] rcorr, tcorr;
  logic [EOF_W-1:0] eof_len;
  logic [DIV_W:0] rlen, tlen;
  logic fall;
  logic [3:0] last_stop;
  logic [EST_W-1:0] q_full;
  logic [3:0] rem;
  logic wr, rd_setup, buf_free, buf_take;

  assign mode = ctrl_r[CTRL_MODE_LO +: 2];
  assign use_est = (mode == MODE_AUTO) && est_valid_r;
  assign rdiv = use_est ? est_div_r : div_r;
  assign rcorr = use_est ? est_corr_r : rx_corr_r;
  assign tdiv = use_est ? est_div_r
              : div_r + {{(DIV_W-1){1'b0}}, ctrl_r[CTRL_TX_DIV1]};
  assign tcorr = use_est ? est_corr_r : tx_corr_r;
  assign eof_len = (eof_r == '0) ? {{(EOF_W-1){1'b0}}, 1'b1}
                 : (eof_r > EOF_MAX) ? EOF_MAX : eof_r;
  assign rlen = bitlen(rdiv, rcorr, bi_r);
  assign tlen = bitlen(tdiv, tcorr, tbi_r);
  assign fall = rx_s3_r && !rx_s2_r;
  assign last_stop = ctrl_r[CTRL_RX_STOP2] ? LAST_STOP2 : LAST_STOP1;
  assign q_full = ecnt_r / EST_W'(CAL_BITS);
  assign rem = 4'(ecnt_r % EST_W'(CAL_BITS));
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable;
  assign buf_free = wr && (apb_req.paddr == OFF_BUFREL) && apb_req.pwdata[0];

  // rx line resynchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_line;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  // receive sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r <= RX_IDLE;
      cnt_r <= '0;
      bi_r <= '0;
      sh_r <= '0;
      ecnt_r <= '0;
      eofcnt_r <= '0;
      est_div_r <= DIV_RST;
      est_corr_r <= '0;
      est_valid_r <= 1'b0;
      fer_set <= 1'b0;
      deliver <= 1'b0;
      eor_r <= 1'b0;
    end else begin
      fer_set <= 1'b0;
      deliver <= 1'b0;
      eor_r <= 1'b0;
      case (rx_st_r)
        RX_IDLE: begin
          if (fall && mode != MODE_OFF) begin
            rx_st_r <= RX_CAL;
            // the lagged line samples count the rest of the low time
            ecnt_r <= EST_W'(1);
          end else if (fall) begin
            rx_st_r <= RX_BITS;
            cnt_r <= (DIV_W+1)'(START_PRELOAD);
            bi_r <= '0;
          end
        end
        RX_CAL: begin
          if (rx_s2_r) begin
            if (&ecnt_r) begin
              est_div_r <= EST_OVF_DIV;
              est_corr_r <= '0;
              fer_set <= 1'b1;
            end else begin
              est_div_r <= DIV_W'(q_full);
              est_corr_r <= spread(rem);
              sh_r <= 8'h00;
              deliver <= ctrl_r[CTRL_KEEP];
            end
            est_valid_r <= 1'b1;
            rx_st_r <= RX_GAP;
            cnt_r <= (DIV_W+1)'(1);
            eofcnt_r <= '0;
          end else if (!(&ecnt_r)) begin
            ecnt_r <= ecnt_r + EST_W'(1);
          end
        end
        RX_BITS: begin
          cnt_r <= cnt_r + (DIV_W+1)'(1);
          if (cnt_r == {2'b00, rdiv[DIV_W-1:1]}) begin
            if (bi_r == 4'h0 && rx_s2_r) begin
              rx_st_r <= (eofcnt_r != '0 || bytes_r != '0) ? RX_GAP : RX_IDLE;
              cnt_r <= (DIV_W+1)'(1);
            end else if (bi_r >= 4'h1 && bi_r <= 4'h8) begin
              sh_r <= {rx_s2_r, sh_r[7:1]};
            end else if (bi_r >= LAST_STOP1) begin
              fer_set <= !rx_s2_r;
              deliver <= (bi_r == last_stop);
            end
          end
          if (cnt_r >= rlen) begin
            cnt_r <= (DIV_W+1)'(1);
            bi_r <= bi_r + 4'h1;
            if (bi_r == last_stop) begin
              rx_st_r <= RX_GAP;
              eofcnt_r <= '0;
            end
          end
        end
        RX_GAP: begin
          cnt_r <= cnt_r + (DIV_W+1)'(1);
          if (fall) begin
            rx_st_r <= RX_BITS;
            cnt_r <= (DIV_W+1)'(START_PRELOAD);
            bi_r <= '0;
          end else if (!rx_s2_r) begin
            // a low line is no idle bit: restart the run of ones
            cnt_r <= (DIV_W+1)'(1);
            eofcnt_r <= '0;
          end else if (cnt_r >= {1'b0, rdiv}) begin
            cnt_r <= (DIV_W+1)'(1);
            eofcnt_r <= eofcnt_r + EOF_W'(1);
            if (eofcnt_r + EOF_W'(1) == eof_len) begin
              eor_r <= 1'b1;
              rx_st_r <= RX_IDLE;
              eofcnt_r <= '0;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // byte delivery and overflow guard
  assign ovf_set = deliver && (bytes_r >= {1'b0, bufsz_r});
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bytes_r <= '0;
      ovf_frame_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= '0;
    end else begin
      rx_valid_r <= deliver && !ovf_set && !ovf_frame_r;
      if (deliver) begin
        rx_data_r <= sh_r;
        if (!ovf_set) begin
          bytes_r <= bytes_r + (BSZ_W+1)'(1);
        end
      end
      if (ovf_set) begin
        ovf_frame_r <= 1'b1;
      end
      if (eor_r) begin
        bytes_r <= '0;
        ovf_frame_r <= 1'b0;
      end
    end
  end

  // buffer availability and rts
  assign buf_take = eor_r && !ovf_frame_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bufcnt_r <= NUM_BUFS;
      rts_b_r <= 1'b0;
    end else begin
      if (buf_free && !buf_take && bufcnt_r != NUM_BUFS) begin
        bufcnt_r <= bufcnt_r + 3'h1;
      end else if (buf_take && !buf_free && bufcnt_r != '0) begin
        bufcnt_r <= bufcnt_r - 3'h1;
      end
      if (buf_free) begin
        rts_b_r <= 1'b0;
      end else if (buf_take && bufcnt_r <= 3'h1) begin
        rts_b_r <= 1'b1;
      end
    end
  end

  // byte transmitter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r <= TX_IDLE;
      tcnt_r <= '0;
      tbi_r <= '0;
      tsh_r <= '1;
      tx_line_r <= 1'b1;
      tx_ack_r <= 1'b0;
    end else begin
      tx_ack_r <= 1'b0;
      case (tx_st_r)
        TX_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_valid && !tx_ack_r && !cts_b) begin
            tx_st_r <= TX_BITS;
            tsh_r <= {1'b1, tx_data, 1'b0};
            tx_line_r <= 1'b0;
            tcnt_r <= (DIV_W+1)'(1);
            tbi_r <= '0;
          end
        end
        TX_BITS: begin
          tcnt_r <= tcnt_r + (DIV_W+1)'(1);
          if (tcnt_r >= tlen) begin
            tcnt_r <= (DIV_W+1)'(1);
            tbi_r <= tbi_r + 4'h1;
            tsh_r <= {1'b1, tsh_r[9:1]};
            tx_line_r <= tsh_r[1];
            if (tbi_r == (ctrl_r[CTRL_TX_STOP2] ? LAST_STOP2
                          : LAST_STOP1)) begin
              tx_st_r <= TX_IDLE;
              tx_line_r <= 1'b1;
              tx_ack_r <= 1'b1;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // apb register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= '0;
      div_r <= DIV_RST;
      rx_corr_r <= '0;
      tx_corr_r <= '0;
      eof_r <= EOF_RST;
      bufsz_r <= BUFSZ_RST;
    end else if (wr) begin
      case (apb_req.paddr)
        OFF_CTRL: ctrl_r <= apb_req.pwdata[5:0];
        OFF_DIV: div_r <= apb_req.pwdata[DIV_W-1:0];
        OFF_CORR: begin
          rx_corr_r <= apb_req.pwdata[CORR_W-1:0];
          tx_corr_r <= apb_req.pwdata[CORR_TX_LO +: CORR_W];
        end
        OFF_EOF: eof_r <= apb_req.pwdata[EOF_W-1:0];
        OFF_BUFSZ: bufsz_r <= apb_req.pwdata[BSZ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fer_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      if (fer_set) begin
        fer_r <= 1'b1;
      end else if (wr && apb_req.paddr == OFF_STAT
                   && apb_req.pwdata[STAT_FER]) begin
        fer_r <= 1'b0;
      end
      if (ovf_set) begin
        ovf_r <= 1'b1;
      end else if (wr && apb_req.paddr == OFF_STAT
                   && apb_req.pwdata[STAT_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // apb read data and answer, captured in the setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= 1'b1;
      if (rd_setup) begin
        rsp_r.pslverr <= 1'b0;
        rsp_r.prdata <= '0;
        case (apb_req.paddr)
          OFF_CTRL: rsp_r.prdata[5:0] <= ctrl_r;
          OFF_DIV: rsp_r.prdata[DIV_W-1:0] <= div_r;
          OFF_CORR: begin
            rsp_r.prdata[CORR_W-1:0] <= rx_corr_r;
            rsp_r.prdata[CORR_TX_LO +: CORR_W] <= tx_corr_r;
          end
          OFF_EOF: rsp_r.prdata[EOF_W-1:0] <= eof_r;
          OFF_EST_DIV: rsp_r.prdata[DIV_W-1:0] <= est_div_r;
          OFF_EST_CORR: rsp_r.prdata[CORR_W-1:0] <= est_corr_r;
          OFF_STAT: rsp_r.prdata[5:0] <= {bufcnt_r, est_valid_r, ovf_r, fer_r};
          OFF_BUFSZ: rsp_r.prdata[BSZ_W-1:0] <= bufsz_r;
          OFF_BUFREL: ;
          default: rsp_r.pslverr <= 1'b1;
        endcase
      end
    end
  end

  assign apb_rsp = rsp_r;
  assign tx_line = tx_line_r;
  assign rts_b = rts_b_r;
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign eor = eor_r;
  assign tx_ack = tx_ack_r;
  assign fer_flag = fer_r;
  assign ovf_flag = ovf_r;
endmodule
`default_nettype wire

// ===== verification/hsur_host_model.sv
/*
  behavioural host uart: sends bytes on rx_line, collects bytes on tx_line.
  assumes the bench paces it in sample clock cycles.
*/
`default_nettype none
module hsur_host_model (
  // clock
  input wire logic clk,
  // uart pins
  output logic rx_line,
  output logic cts_b,
  input wire logic tx_line,
  input wire logic rts_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int rcyc = 16;
  logic [7:0] got_q[$];
  logic [7:0] rb;
  initial begin
    rx_line = 1'b1;
    cts_b = 1'b0;
  end
  task automatic set_cts(input logic v);
    cts_b <= v;
  endtask
  // start 0, data lsb first, one stop; stp low forces a bad stop
  task automatic send(input logic [7:0] b, input int cyc, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (cyc) @(posedge clk);
    end
    // after a bad stop the line idles one bit before the next start
    if (!stp) begin
      rx_line <= 1'b1;
      repeat (cyc) @(posedge clk);
    end
  endtask
  // samples each bit of the device's byte at mid-bit
  always begin
    @(negedge tx_line);
    repeat (rcyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (rcyc) @(posedge clk);
      rb[i] = tx_line;
    end
    repeat (rcyc) @(posedge clk);
    got_q.push_back(rb);
  end
endmodule
`default_nettype wire

// ===== verification/hsur_receiver_chk.sv
/*
  concurrent checks on the ports of the uart receive path.
  assumes one clock, active-low async reset and zero-wait apb.
*/
`default_nettype none
module hsur_receiver_chk #(
  parameter int EST_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb
  input wire hsur_pkg::hsur_apb_req_t apb_req,
  input wire hsur_pkg::hsur_apb_rsp_t apb_rsp,
  // uart pins
  input wire logic rx_line,
  input wire logic cts_b,
  input wire logic tx_line,
  input wire logic rts_b,
  // buffer side
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic eor,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ack,
  // flags
  input wire logic fer_flag,
  input wire logic ovf_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import hsur_pkg::*;
  logic wr_c;
  logic tx_idle_r;
  logic ovf_d_r;
  logic ovf_fr_r;
  int hi_r;
  int div_r;
  int eof_r;
  logic [1:0] mode_r;
  assign wr_c = apb_req.psel && apb_req.penable && apb_req.pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of the timing registers as software writes them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= int'(DIV_RST);
      eof_r <= int'(EOF_RST);
      mode_r <= MODE_OFF;
    end else if (wr_c) begin
      if (apb_req.paddr == OFF_DIV) div_r <= int'(apb_req.pwdata[11:0]);
      if (apb_req.paddr == OFF_EOF) eof_r <= int'(apb_req.pwdata[6:0]);
      if (apb_req.paddr == OFF_CTRL) mode_r <= apb_req.pwdata[1:0];
    end
  end
  // length of the current run of ones on the receive line
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hi_r <= 0;
    else if (!rx_line) hi_r <= 0;
    else if (hi_r < 100000) hi_r <= hi_r + 1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) tx_idle_r <= 1'b1;
    else if (tx_ack) tx_idle_r <= 1'b1;
    else if (!tx_line) tx_idle_r <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_d_r <= 1'b0;
      ovf_fr_r <= 1'b0;
    end else begin
      ovf_d_r <= ovf_flag;
      if (ovf_flag && !ovf_d_r) ovf_fr_r <= 1'b1;
      else if (eor) ovf_fr_r <= 1'b0;
    end
  end
  chk_fer_sticky: assert property (fer_flag && !(wr_c &&
    apb_req.paddr == OFF_STAT && apb_req.pwdata[STAT_FER]) |=> fer_flag)
    else $error("framing flag dropped without clear");
  chk_ovf_sticky: assert property (ovf_flag && !(wr_c &&
    apb_req.paddr == OFF_STAT && apb_req.pwdata[STAT_OVF]) |=> ovf_flag)
    else $error("overflow flag dropped without clear");
  chk_rts_rise: assert property ($rose(rts_b) |-> eor || $past(eor))
    else $error("rts rose outside frame end");
  chk_rts_fall: assert property ($fell(rts_b) |->
    $past(wr_c && apb_req.paddr == OFF_BUFREL && apb_req.pwdata[0]))
    else $error("rts fell without buffer release");
  chk_tx_start: assert property (tx_idle_r && !tx_line |->
    $past(!cts_b && tx_valid)) else $error("start bit without cts");
  chk_cts_hold: assert property (tx_idle_r && tx_line && cts_b |=>
    tx_line) else $error("byte sent while cts high");
  chk_eor_idle: assert property (eor && mode_r == MODE_OFF |->
    hi_r >= (eof_r - 1) * div_r) else $error("frame end too early");
  chk_ovf_rts: assert property (eor && ovf_fr_r && !rts_b |=>
    !rts_b [*2]) else $error("rts rose after overflow");
  chk_ack_stop: assert property (tx_ack |-> tx_line && $past(tx_line))
    else $error("ack without stop level");
  cover property (eor);
  cover property ($rose(fer_flag));
  cover property ($rose(ovf_flag));
  cover property (tx_ack);
endmodule
bind hsur_receiver hsur_receiver_chk #(.EST_W(EST_W)) u_chk (.clk, .rst_b,
  .apb_req, .apb_rsp, .rx_line, .cts_b, .tx_line, .rts_b, .rx_valid,
  .rx_data, .eor, .tx_valid, .tx_data, .tx_ack, .fer_flag, .ovf_flag);
`default_nettype wire

// ===== verification/hsur_receiver_tb.sv
/*
  self-checking bench for the uart receive path with a host model.
  assumes the checker is bound to the design by its own file.
*/
`default_nettype none
module hsur_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hsur_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  hsur_apb_req_t req = '0;
  hsur_apb_rsp_t rsp;
  logic rx_line, cts_b, tx_line, rts_b, rx_valid, eor, tx_ack;
  logic fer_flag, ovf_flag;
  logic [7:0] rx_data;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int eor_n = 0;
  logic [7:0] got_q[$];
  logic [31:0] rd_v;
  logic er;
  always #2.5 clk = ~clk;
  hsur_receiver #(.EST_W(8)) DUT (.clk, .rst_b, .apb_req(req),
    .apb_rsp(rsp), .rx_line, .cts_b, .tx_line, .rts_b, .rx_valid,
    .rx_data, .eor, .tx_valid, .tx_data, .tx_ack, .fer_flag, .ovf_flag);
  hsur_host_model host (.clk, .rx_line, .cts_b, .tx_line, .rts_b);
  task finish_test;
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) got_q.push_back(rx_data);
    if (eor === 1'b1) eor_n++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd_v = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  task exp_q(input logic [31:0] v, input int n);
    chk(32'(got_q.size()), 32'(n));
    for (int i = 0; i < n && got_q.size() > 0; i++)
      chk(32'(got_q.pop_front()), 32'(v[8*i+:8]));
    got_q.delete();
  endtask
  // bytes back to back, then the inter-frame gap of eof plus five bits
  task frame(input logic [31:0] v, input int n, input int c);
    for (int i = 0; i < n; i++) host.send(v[8*i+:8], c, 1'b1);
    repeat (9 * c) @(posedge clk);
  endtask
  task tx(input logic [7:0] b, input int rc);
    host.rcyc = rc;
    tx_valid <= 1'b1;
    tx_data <= b;
    do @(posedge clk); while (tx_ack !== 1'b1);
    tx_valid <= 1'b0;
    repeat (2 * rc) @(posedge clk);
    chk(32'(host.got_q.size()), 32'h1);
    if (host.got_q.size() > 0) chk(32'(host.got_q.pop_front()), 32'(b));
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(32'(rts_b), 32'h0);
    rd(OFF_DIV, 32'(DIV_RST));
    rd(OFF_EOF, 32'(EOF_RST));
    rd(OFF_BUFSZ, 32'(BUFSZ_RST));
    rd(OFF_STAT, 32'(NUM_BUFS) << STAT_BUF_LO);
    rd(8'h24, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, OFF_DIV, 32'h10);
    apb(1'b1, OFF_EOF, 32'h4);
    frame(32'h3ca5, 2, 16);
    exp_q(32'h3ca5, 2);
    chk(32'(eor_n), 32'h1);
    rd(OFF_STAT, 32'h18);
    apb(1'b1, OFF_CORR, 32'h7ff);
    frame(32'h81, 1, 17);
    exp_q(32'h81, 1);
    apb(1'b1, OFF_CORR, 32'h0);
    frame(32'h01, 1, 16);
    chk(32'(rts_b), 32'h0);
    frame(32'h02, 1, 16);
    chk(32'(rts_b), 32'h1);
    exp_q(32'h0201, 2);
    apb(1'b1, OFF_BUFREL, 32'h1);
    chk(32'(rts_b), 32'h0);
    repeat (3) apb(1'b1, OFF_BUFREL, 32'h1);
    host.send(8'h11, 16, 1'b0);
    frame(32'h22, 1, 16);
    chk(32'(fer_flag), 32'h1);
    exp_q(32'h2211, 2);
    apb(1'b1, OFF_STAT, 32'h1);
    chk(32'(fer_flag), 32'h0);
    apb(1'b1, OFF_BUFSZ, 32'h2);
    frame(32'h030201, 3, 16);
    chk(32'(ovf_flag), 32'h1);
    exp_q(32'h0201, 2);
    chk(32'(rts_b), 32'h0);
    apb(1'b1, OFF_STAT, 32'h2);
    apb(1'b1, OFF_BUFSZ, 32'(BUFSZ_RST));
    host.set_cts(1'b1);
    tx_valid <= 1'b1;
    tx_data <= 8'h96;
    repeat (40) @(posedge clk);
    chk(32'(tx_line), 32'h1);
    host.set_cts(1'b0);
    tx(8'h96, 16);
    // two stop bits both ways and the transmit divider one longer
    apb(1'b1, OFF_CTRL, 32'h38);
    frame(32'h5a, 1, 16);
    exp_q(32'h5a, 1);
    chk(32'(fer_flag), 32'h0);
    tx(8'h3c, 17);
    apb(1'b1, OFF_CTRL, 32'(MODE_AUTO));
    tx(8'h5c, 16);
    frame(32'h3300, 2, 20);
    exp_q(32'h33, 1);
    apb(1'b0, OFF_EST_DIV, 32'h0);
    // resync jitter may move the count by a cycle either way
    chk(32'(rd_v >= 32'd19 && rd_v <= 32'd21), 32'h1);
    tx(8'ha7, 20);
    apb(1'b1, OFF_CTRL, 32'(MODE_REPORT) | 32'h4);
    host.send(8'h00, 20, 1'b1);
    frame(32'h44, 1, 16);
    exp_q(32'h4400, 2);
    host.send(8'h00, 32, 1'b1);
    repeat (9 * 32) @(posedge clk);
    chk(32'(fer_flag), 32'h1);
    rd(OFF_EST_DIV, 32'(EST_OVF_DIV));
    finish_test();
  end
endmodule
`default_nettype wire
